//--- sgp_assertions.sv
`timescale 1ns/1ns
module sgp_assertions (
    input wire clk, input wire rst_b, input wire [7:0] cmdCode, input wire wrStrobe,
    input wire [15:0] wrData, input wire rdStrobe, input wire rdValid,
    input wire powerFeedbackSel, input wire [4:0] biasLoopGain,
    input wire [4:0] powerLoopGain, input wire [2:0] modLoopGain, input wire [4:0] edgeBoost
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
AST_RD_ON:
assert property (rdStrobe |=> rdValid) else $error("rd on");
AST_RD_OFF:
assert property (!rdStrobe |=> !rdValid) else $error("rd off");
AST_MOD_WR:
assert property (wrStrobe && cmdCode == 8'h1e |=> modLoopGain == $past(wrData[2:0]))
    else $error("mod");
AST_EDGE_WR:
assert property (wrStrobe && cmdCode == 8'h1f |=> edgeBoost == $past(wrData[4:0]))
    else $error("edge");
AST_EDGE_HOLD:
assert property (!(wrStrobe && cmdCode == 8'h1f) |=> $stable(edgeBoost)) else $error("hold");
AST_BIAS_WR:
assert property (wrStrobe && cmdCode == 8'h1e ##1 !wrStrobe && !powerFeedbackSel
    |=> biasLoopGain == $past(wrData[7:3], 2)) else $error("bias");
AST_BIAS_OFF:
assert property (powerFeedbackSel |=> biasLoopGain == 5'h00) else $error("bias off");
AST_PWR_OFF:
assert property (!powerFeedbackSel |=> powerLoopGain == 5'h00) else $error("pwr off");
endmodule // sgp_assertions
bind sgp_servo_gain_peaking_regs sgp_assertions u_chk (.clk(clk), .rst_b(rst_b),
    .cmdCode(cmdCode), .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
    .rdValid(rdValid), .powerFeedbackSel(powerFeedbackSel), .biasLoopGain(biasLoopGain),
    .powerLoopGain(powerLoopGain), .modLoopGain(modLoopGain), .edgeBoost(edgeBoost));

//--- sgp_defs.vh
`ifndef SGP_DEFS_VH
`define SGP_DEFS_VH

// ********************************************************
// serial command codes
// ********************************************************
`define SGP_CMD_TEST      8'h08
`define SGP_CMD_LOOP_GAIN 8'h1e
`define SGP_CMD_EDGE      8'h1f

// ********************************************************
// reset values and writable masks
// ********************************************************
`define SGP_LOOP_RESET    16'h0021
`define SGP_LOOP_MASK     16'h00ff
`define SGP_EDGE_RESET    16'h0010
`define SGP_EDGE_MASK     16'h001f
`define SGP_TEST_RESET    16'h0044
`define SGP_TEST_MASK     16'h007f

// ********************************************************
// field positions
// ********************************************************
`define SGP_BIAS_HI       7
`define SGP_BIAS_LO       3
`define SGP_MOD_HI        2
`define SGP_MOD_LO        0
`define SGP_BOOST_HI      4
`define SGP_BOOST_LO      0

`define SGP_WORD_BITS     16
`define SGP_ZERO_WORD     16'h0000
`define SGP_ZERO_BIAS     5'h00

`endif

//--- sgp_host_model.sv
`timescale 1ns/1ns
module sgp_host_model (
    input  wire        clk,
    input  wire [15:0] rdData,
    output reg  [7:0]  cmdCode = 8'h00,
    output reg         wrStrobe = 1'b0,
    output reg  [15:0] wrData = 16'h0000,
    output reg         rdStrobe = 1'b0
);
task wr(input [7:0] c, input [15:0] d); begin
    @(posedge clk);
    cmdCode <= c;
    wrData <= d;
    wrStrobe <= (c != 8'h08);
    @(posedge clk);
    wrStrobe <= 1'b0;
    wrData <= ~d;
end endtask
task rd(input [7:0] c, output [15:0] d); begin
    @(posedge clk);
    cmdCode <= c;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
end endtask
endmodule // sgp_host_model

//--- sgp_servo_gain_peaking_regs.v
// Functional notes
// (R01) loop gain 0x1e: bias gain 7:3, reset 00100
// (R02) bias field steers current or power loop
// (R03) current loop gain independent of range
// (R04) modulation gain bits 2:0, reset 001
// (R05) reset gains slow but stable
// (R06) edge boost 0x1f bits 4:0, reset 10000
// (R07) lower boost, more falling undershoot
// (R08) host never writes test register 0x08
// (R09) power feedback select chooses gain meaning
// (R10) reserved bits read zero, writes ignored
`timescale 1ns/1ns
`include "sgp_defs.vh"

module sgp_servo_gain_peaking_regs (
    // clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // serial command access
    input  wire [7:0]  cmdCode,
    input  wire        wrStrobe,
    input  wire [15:0] wrData,
    input  wire        rdStrobe,
    output reg  [15:0] rdData,
    output reg         rdValid,
    // mode from system configuration
    input  wire        powerFeedbackSel,
    // analog control outputs
    output reg  [4:0]  biasLoopGain,
    output reg  [4:0]  powerLoopGain,
    output wire [2:0]  modLoopGain,
    output wire [4:0]  edgeBoost
);

    // ********************************************************
    // internal signals
    // ********************************************************
    wire [15:0] loopWord;
    wire [15:0] edgeWord;
    wire [15:0] testWord;
    wire [15:0] loopRead;
    wire [15:0] edgeRead;
    wire [15:0] testRead;
    wire        wrLoop;
    wire        wrEdge;
    wire        wrTest;
    reg         hitLoop;
    reg         hitEdge;
    reg         hitTest;
    reg  [4:0]  next_biasLoopGain;
    reg  [4:0]  next_powerLoopGain;
    reg  [15:0] next_rdData;

    localparam [15:0] LOOP_MASK = `SGP_LOOP_MASK;
    localparam [15:0] EDGE_MASK = `SGP_EDGE_MASK;
    localparam [15:0] TEST_MASK = `SGP_TEST_MASK;

    // ********************************************************
    // command decode
    // ********************************************************
    always @* begin
        hitLoop = 1'b0;
        hitEdge = 1'b0;
        hitTest = 1'b0;
        case (cmdCode)
            `SGP_CMD_LOOP_GAIN: begin
                hitLoop = 1'b1;
            end
            `SGP_CMD_EDGE: begin
                hitEdge = 1'b1;
            end
            `SGP_CMD_TEST: begin
                hitTest = 1'b1;
            end
            default: begin
                hitLoop = 1'b0;
            end
        endcase
    end

    // ********************************************************
    // write strobes
    // ********************************************************
    assign wrLoop = wrStrobe && hitLoop;
    assign wrEdge = wrStrobe && hitEdge;
    // (R08) stored if written anyway
    assign wrTest = wrStrobe && hitTest;

    // ********************************************************
    // loop gain word
    // ********************************************************
    // (R01) loop gain word
    sgp_word_reg #(
        .RESET_VALUE (`SGP_LOOP_RESET),
        .WRITE_MASK  (`SGP_LOOP_MASK)
    ) loopReg (
        .clk    (clk),
        .rst_b  (rst_b),
        .wrEn   (wrLoop),
        .wrData (wrData),
        .q      (loopWord)
    );

    // ********************************************************
    // edge boost word
    // ********************************************************
    // (R06) edge boost word
    sgp_word_reg #(
        .RESET_VALUE (`SGP_EDGE_RESET),
        .WRITE_MASK  (`SGP_EDGE_MASK)
    ) edgeReg (
        .clk    (clk),
        .rst_b  (rst_b),
        .wrEn   (wrEdge),
        .wrData (wrData),
        .q      (edgeWord)
    );

    // ********************************************************
    // test word
    // ********************************************************
    sgp_word_reg #(
        .RESET_VALUE (`SGP_TEST_RESET),
        .WRITE_MASK  (`SGP_TEST_MASK)
    ) testReg (
        .clk    (clk),
        .rst_b  (rst_b),
        .wrEn   (wrTest),
        .wrData (wrData),
        .q      (testWord)
    );

    // ********************************************************
    // reserved bit masking
    // ********************************************************
    // (R10) reserved read zero
    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < `SGP_WORD_BITS; bitIdx = bitIdx + 1) begin : g_readMask
            assign loopRead[bitIdx] = loopWord[bitIdx] & LOOP_MASK[bitIdx];
            assign edgeRead[bitIdx] = edgeWord[bitIdx] & EDGE_MASK[bitIdx];
            assign testRead[bitIdx] = testWord[bitIdx] & TEST_MASK[bitIdx];
        end
    endgenerate

    // ********************************************************
    // field outputs
    // ********************************************************
    // (R04) modulation gain field
    assign modLoopGain = loopWord[`SGP_MOD_HI:`SGP_MOD_LO];
    // (R07) boost to output stage
    assign edgeBoost   = edgeWord[`SGP_BOOST_HI:`SGP_BOOST_LO];

    // ********************************************************
    // loop mode steering
    // ********************************************************
    // (R09) select steers field
    always @* begin
        next_biasLoopGain  = `SGP_ZERO_BIAS;
        next_powerLoopGain = `SGP_ZERO_BIAS;
        if (powerFeedbackSel) begin
            // (R02) power loop gain
            next_powerLoopGain = loopWord[`SGP_BIAS_HI:`SGP_BIAS_LO];
        end else begin
            // (R03) range not applied
            next_biasLoopGain = loopWord[`SGP_BIAS_HI:`SGP_BIAS_LO];
        end
    end

    // (R05) gains registered, cleared to zero in reset
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            biasLoopGain  <= `SGP_ZERO_BIAS;
            powerLoopGain <= `SGP_ZERO_BIAS;
        end else begin
            biasLoopGain  <= next_biasLoopGain;
            powerLoopGain <= next_powerLoopGain;
        end
    end

    // ********************************************************
    // read back
    // ********************************************************
    // (R10) reserved read zero
    always @* begin
        next_rdData = `SGP_ZERO_WORD;
        if (hitLoop) begin
            next_rdData = loopRead;
        end else if (hitEdge) begin
            next_rdData = edgeRead;
        end else if (hitTest) begin
            next_rdData = testRead;
        end else begin
            next_rdData = `SGP_ZERO_WORD;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= `SGP_ZERO_WORD;
        end else if (rdStrobe) begin
            rdData <= next_rdData;
        end
    end

    // ********************************************************
    // read strobe capture
    // ********************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStrobe;
        end
    end

endmodule // sgp_servo_gain_peaking_regs

//--- sgp_servo_gain_peaking_regs_tb_top.sv
`timescale 1ns/1ns
module sgp_servo_gain_peaking_regs_tb_top;
reg clk = 0, rst_b = 0, sel = 0;
reg [15:0] lw = 16'h0021, ew = 16'h0010, d, r;
reg [7:0] c;
wire [7:0] cmdCode;
wire wrStrobe, rdStrobe, rdValid;
wire [15:0] wrData, rdData;
wire [4:0] biasG, pwrG, edgeG;
wire [2:0] modG;
integer error_cnt = 0, n_compared = 0, seed = 13188, cyc = 0, i;
sgp_host_model u_host (.clk(clk), .rdData(rdData), .cmdCode(cmdCode),
    .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe));
sgp_servo_gain_peaking_regs u_dut (.clk(clk), .rst_b(rst_b), .cmdCode(cmdCode),
    .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe), .rdData(rdData),
    .rdValid(rdValid),
    .powerFeedbackSel(sel), .biasLoopGain(biasG), .powerLoopGain(pwrG),
    .modLoopGain(modG), .edgeBoost(edgeG));
task chk(input [31:0] n, input [17:0] e, input [17:0] g); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s exp %h got %h", n, e, g);
    end
end endtask
task close_out; begin
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
end endtask
initial forever #2 clk = ~clk;
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
        error_cnt = error_cnt + 1;
        close_out;
    end
end
initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    u_host.rd(8'h1e, r);
    chk("loop", 16'h0021, r);
    chk("vldr", 18'h00001, rdValid);
    u_host.rd(8'h1f, r);
    chk("edge", 16'h0010, r);
    u_host.rd(8'h08, r);
    chk("test", 16'h0044, r);
    for (i = 0; i < 60; i = i + 1) begin
        @(posedge clk);
        sel <= $random(seed);
        d = $random(seed);
        c = (i % 3 == 0) ? 8'h1e : (i % 3 == 1) ? 8'h1f : 8'h5a;
        u_host.wr(c, d);
        if (c == 8'h1e) lw = d & 16'h00ff;
        if (c == 8'h1f) ew = d & 16'h001f;
        @(posedge clk);
        #1;
        chk("outs", {sel ? 5'h00 : lw[7:3], sel ? lw[7:3] : 5'h00, lw[2:0], ew[4:0]},
            {biasG, pwrG, modG, edgeG});
        chk("vld0", 18'h00000, rdValid);
        u_host.rd(c, r);
        chk("vld1", 18'h00001, rdValid);
        chk("read", (c == 8'h1e) ? lw : (c == 8'h1f) ? ew : 16'h0000, r);
    end
    close_out;
end
endmodule // sgp_servo_gain_peaking_regs_tb_top

//--- sgp_word_reg.v
`timescale 1ns/1ns

// ********************************************************
// one masked register word
// ********************************************************
module sgp_word_reg #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK  = 16'hffff
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // write side
    input  wire        wrEn,
    input  wire [15:0] wrData,
    // stored word
    output reg  [15:0] q
);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= RESET_VALUE;
        end else if (wrEn) begin
            // (R10) masked bits dropped
            q <= wrData & WRITE_MASK;
        end
    end

endmodule // sgp_word_reg
